// ==== hw/dca_map.svh ====
`ifndef DCA_MAP_SVH
`define DCA_MAP_SVH
// register byte offsets
`define DCA_OFS_CTRL   32'h0000_0000
`define DCA_OFS_MODE   32'h0000_0004
`define DCA_OFS_STAT   32'h0000_0008
// control register fields
`define DCA_CE_LSB     0
`define DCA_ME_LSB     8
`define DCA_FULL_LSB   12
// mode register fields
`define DCA_HOLD_LSB   0
// status register fields
`define DCA_PEND_LSB   0
`define DCA_ACT_LSB    8
`define DCA_BUSREQ_BIT 16
`define DCA_BUSY_BIT   17
// reset values
`define DCA_CTRL_RST   16'h0000
`define DCA_MODE_RST   8'h00
// bus responses
`define DCA_RESP_OK    2'h0
`define DCA_RESP_ERR   2'h2
`endif

// ==== hw/dca_pkg.sv ====
package dca_pkg;
  // arbitration states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ  = 4'h2,
    ST_XFER = 4'h4,
    ST_DEAD = 4'h8
  } dca_state_type;
  // axi4-lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } dca_axi_req_type;
  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dca_axi_rsp_type;
endpackage : dca_pkg

// ==== hw/dca_arbiter.sv ====
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "dca_map.svh"
// Summary of operation
// - fixed priority 0A highest down to 3B
// - request bus, grant serves highest pending channel
// - same-group requests wait while channel owns bus
// - single units release bus, then re-request
// - burst or block yields after current unit
// - group 0 wins over group 1
// - in unit mode, other group pending starts without releasing
// - group 0 request preempts group 1 burst
// - cycle-steal groups may alternate holding bus
// - external or refresh request releases after unit
// - short address mode ignores nmi
// - full mode needs channel and master enable
// - nmi clears master enable, suspends after unit
// - setting master enable resumes suspended transfer
// - clearing channel enable stops after unit
// - master enable halts and restarts likewise
// - reset initialises everything, standby all but the register bus port
// - sleep does not stop transfers
// - abort with pending request inserts dead cycle
// - burst holds bus until done or preempted
module dca_arbiter
  import dca_pkg::*;
(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // register bus
  input  wire dca_axi_req_type axi_req,
  output dca_axi_rsp_type      axi_rsp,
  // transfer requests per sub-channel 0A..3B
  input  wire logic [7:0]      xfer_req,
  // datapath: current read-write pair finished
  input  wire logic            unit_done,
  // system bus arbitration
  output logic                 bus_req,
  input  wire logic            bus_grant,
  input  wire logic            external_bus_request,
  input  wire logic            refresh_req,
  // system events
  input  wire logic            nmi,
  input  wire logic            standby,
  // channel activity toward datapath
  output logic [7:0]           act_ch,
  output logic                 unit_start,
  output logic                 unit_busy,
  output logic                 dead_cycle
);

  ////////////////////////////////////////////////////////////////
  // helpers

  // lowest set bit wins: index 0 is channel 0A
  function automatic logic [7:0] pick(input logic [7:0] v);
    pick = v & (~v + 8'h01);
  endfunction : pick

  // byte-lane merge for strobed writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////
  // state

  dca_state_type st_r;              // arbitration state
  logic [7:0]    ce_r;              // channel_enable_bit per sub-channel
  logic [3:0]    me_r;              // master_enable_bit per pair
  logic [3:0]    full_r;            // full address mode per pair
  logic [7:0]    hold_r;            // burst/block hold per sub-channel
  logic [7:0]    pend_r;            // internal pending flags
  logic [7:0]    act_r;             // owning channel, one-hot
  logic          start_r;           // unit start pulse
  logic          dead_r;            // dead cycle pulse
  logic [7:0]    en;                // effective enable
  logic [7:0]    pend_all;          // pending or arriving now
  logic [7:0]    higher;            // channels above the owner
  logic [7:0]    grp_other;         // channels of the other group
  logic          yield_ext;         // other bus master wants bus
  logic          keep;              // owner continues its burst
  logic          swap;              // hand over without release
  logic          abort;             // owner halted with request
  logic          wr_go;             // register write strobe
  logic [31:0]   aw_r;              // latched write address
  logic [31:0]   wd_r;              // latched write data
  logic [3:0]    ws_r;              // latched write strobes
  logic          aw_ok_r;           // write address held
  logic          w_ok_r;            // write data held
  logic          bv_r;              // write response valid
  logic [1:0]    br_r;              // write response code
  logic          rv_r;              // read data valid
  logic [31:0]   rd_r;              // read data
  logic [1:0]    rr_r;              // read response code

  ////////////////////////////////////////////////////////////////
  // enables and pending decode

  // effective enable; b side dead in full mode
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (full_r[i/2]) begin
        en[i] = ce_r[i] & me_r[i/2] & (i % 2 == 0);
      end else begin
        en[i] = ce_r[i];
      end
    end
  end

  assign pend_all  = (pend_r | xfer_req) & en;
  assign higher    = act_r - 8'h01;
  assign grp_other = (act_r[3:0] != 4'h0) ? 8'hf0 : 8'h0f;
  assign yield_ext = external_bus_request | refresh_req;

  // burst keeps bus unless preempted
  assign keep = |(act_r & hold_r & en & xfer_req) & ~yield_ext
              & ~|(pend_all & higher);
  // unit mode hands over to other group
  assign swap = ~|(act_r & hold_r) & ~yield_ext
              & |(pend_all & grp_other);
  // owner halted while its request was pending
  assign abort = |(act_r & ~en & (pend_r | xfer_req));

  ////////////////////////////////////////////////////////////////
  // pending flags

  // sampled each cycle, cleared on start or disable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= 8'h00;
    end else if (standby) begin
      pend_r <= 8'h00;
    end else begin
      pend_r <= pend_all & ~(start_r ? act_r : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////
  // arbitration state machine, no sleep input so it runs on

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= ST_IDLE;
      act_r   <= 8'h00;
      start_r <= 1'b0;
      dead_r  <= 1'b0;
    end else if (standby) begin
      st_r    <= ST_IDLE;
      act_r   <= 8'h00;
      start_r <= 1'b0;
      dead_r  <= 1'b0;
    end else begin
      start_r <= 1'b0;
      dead_r  <= 1'b0;
      unique case (st_r)
        // no bus: ask when anything is pending
        ST_IDLE: begin
          if (|pend_all) begin
            st_r <= ST_REQ;
          end
        end
        // request held until grant
        ST_REQ: begin
          if (bus_grant) begin
            if (|pend_all) begin
              act_r   <= pick(pend_all);
              start_r <= 1'b1;
              st_r    <= ST_XFER;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        // one read-write pair in flight
        ST_XFER: begin
          if (unit_done) begin
            if (abort) begin
              dead_r <= 1'b1;
              st_r   <= ST_DEAD;
            end else if (keep) begin
              start_r <= 1'b1;
            end else if (swap) begin
              act_r   <= pick(pend_all & grp_other);
              start_r <= 1'b1;
            end else begin
              act_r <= 8'h00;
              st_r  <= ST_IDLE;
            end
          end
        end
        // dead cycle leaves counters untouched
        ST_DEAD: begin
          act_r <= 8'h00;
          st_r  <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus_req    = (st_r == ST_REQ) | (st_r == ST_XFER) | (st_r == ST_DEAD);
  assign unit_busy  = (st_r == ST_XFER);
  assign act_ch     = act_r;
  assign unit_start = start_r;
  assign dead_cycle = dead_r;

  ////////////////////////////////////////////////////////////////
  // control registers

  assign wr_go = aw_ok_r & w_ok_r & ~bv_r;

  // software writes; nmi clears master enable of full pairs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {full_r, me_r, ce_r} <= `DCA_CTRL_RST;
      hold_r               <= `DCA_MODE_RST;
    end else if (standby) begin
      {full_r, me_r, ce_r} <= `DCA_CTRL_RST;
      hold_r               <= `DCA_MODE_RST;
    end else begin
      if (wr_go && aw_r == `DCA_OFS_CTRL) begin
        {full_r, me_r, ce_r} <= 16'(merge({16'h0000, full_r, me_r, ce_r}, wd_r, ws_r));
      end
      if (wr_go && aw_r == `DCA_OFS_MODE) begin
        hold_r <= 8'(merge({24'h0000_00, hold_r}, wd_r, ws_r));
      end
      if (nmi) begin
        me_r <= me_r & ~full_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= `DCA_RESP_OK;
      aw_r    <= 32'h0000_0000;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
    end else begin
      // address and data taken in either order
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_ok_r <= 1'b1;
        aw_r    <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_ok_r <= 1'b1;
        wd_r   <= axi_req.wdata;
        ws_r   <= axi_req.wstrb;
      end
      // both held: commit and answer
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r  <= 1'b0;
        bv_r    <= 1'b1;
        br_r    <= (aw_r == `DCA_OFS_CTRL || aw_r == `DCA_OFS_MODE)
                   ? `DCA_RESP_OK : `DCA_RESP_ERR;
      end else if (bv_r && axi_req.bready) begin
        bv_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rr_r <= `DCA_RESP_OK;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rv_r <= 1'b1;
      rr_r <= `DCA_RESP_OK;
      rd_r <= 32'h0000_0000;
      if (axi_req.araddr[31:8] != 24'h00_0000) begin
        rr_r <= `DCA_RESP_ERR; // unmapped
      end else begin
        unique case (axi_req.araddr)
          `DCA_OFS_CTRL: rd_r <= {16'h0000, full_r, me_r, ce_r};
          `DCA_OFS_MODE: rd_r <= {24'h0000_00, hold_r};
          `DCA_OFS_STAT: rd_r <= {14'h0000, unit_busy, bus_req, act_r, pend_r};
          default:       rr_r <= `DCA_RESP_ERR; // unmapped
        endcase
      end
    end else if (rv_r && axi_req.rready) begin
      rv_r <= 1'b0;
    end
  end

  // ready signals and responses
  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = ~aw_ok_r & ~bv_r;
    axi_rsp.wready  = ~w_ok_r & ~bv_r;
    axi_rsp.bvalid  = bv_r;
    axi_rsp.bresp   = br_r;
    axi_rsp.arready = ~rv_r;
    axi_rsp.rvalid  = rv_r;
    axi_rsp.rdata   = rd_r;
    axi_rsp.rresp   = rr_r;
  end

  ////////////////////////////////////////////////////////////////
  // checks

  sequence s_unit_end;
    (st_r == ST_XFER) && unit_done;
  endsequence

  property p_req_hold;
    @(posedge mclk) disable iff (!arst_n || standby)
      (st_r == ST_REQ) && !bus_grant |=> bus_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request dropped before grant");

  property p_grant_start;
    @(posedge mclk) disable iff (!arst_n || standby)
      (st_r == ST_REQ) && bus_grant && (|pend_all) |=> unit_start && (act_ch != 8'h00);
  endproperty
  a_grant_start: assert property (p_grant_start) else $error("grant did not start a unit");

  property p_top_prio;
    @(posedge mclk) disable iff (!arst_n || standby)
      $rose(st_r == ST_XFER) |-> ((act_r - 8'h01) & $past(pend_all)) == 8'h00;
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("lower channel served first");

  property p_ext_yield;
    @(posedge mclk) disable iff (!arst_n || standby)
      s_unit_end ##0 yield_ext && !abort |=> !bus_req;
  endproperty
  a_ext_yield: assert property (p_ext_yield) else $error("bus kept against other master");

  property p_nmi_full;
    @(posedge mclk) disable iff (!arst_n || standby)
      nmi |=> (me_r & $past(full_r)) == 4'h0;
  endproperty
  a_nmi_full: assert property (p_nmi_full) else $error("nmi left master enable set");

  property p_nmi_short;
    @(posedge mclk) disable iff (!arst_n || standby)
      nmi && !wr_go |=> (me_r & ~full_r) == $past(me_r & ~full_r);
  endproperty
  a_nmi_short: assert property (p_nmi_short) else $error("nmi touched short mode pair");

  sequence s_dead_release;
    dead_cycle && !unit_start ##1 !bus_req;
  endsequence

  property p_dead;
    @(posedge mclk) disable iff (!arst_n || standby)
      s_unit_end ##0 abort |=> s_dead_release;
  endproperty
  a_dead: assert property (p_dead) else $error("abort without dead cycle");

  property p_pend_off;
    @(posedge mclk) disable iff (!arst_n || standby)
      1'b1 |=> (pend_r & ~$past(en)) == 8'h00;
  endproperty
  a_pend_off: assert property (p_pend_off) else $error("pending kept on disabled channel");

  property p_burst_keep;
    @(posedge mclk) disable iff (!arst_n || standby)
      s_unit_end ##0 keep && !abort |=> unit_start && bus_req && act_ch == $past(act_r);
  endproperty
  a_burst_keep: assert property (p_burst_keep) else $error("burst lost the bus");

endmodule : dca_arbiter

// ==== testbench/dca_bus_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// system bus arbiter and datapath seen from the arbitration block
module dca_bus_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // from the arbitration block
  input  wire logic       bus_req,
  input  wire logic       unit_start,
  // latency control: prompt or slow answers
  input  wire logic [3:0] grant_wait,
  input  wire logic [3:0] unit_len,
  // answers
  output logic            bus_grant,
  output logic            unit_done
);
  logic [3:0] gcnt_r;  // cycles the request has waited
  logic [3:0] ucnt_r;  // cycles of the current pair
  logic       run_r;   // a read-write pair is in flight
  // grant grant_wait+1 cycles after the request, kept while the request stands
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gcnt_r    <= 4'h0;
      bus_grant <= 1'b0;
    end else if (!bus_req) begin
      gcnt_r    <= 4'h0;
      bus_grant <= 1'b0;
    end else if (gcnt_r >= grant_wait) begin
      bus_grant <= 1'b1;
    end else begin
      gcnt_r    <= gcnt_r + 4'h1;
    end
  end
  // one pair lasts unit_len+1 cycles, closed by a one-cycle pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_r     <= 1'b0;
      ucnt_r    <= 4'h0;
      unit_done <= 1'b0;
    end else if (unit_start) begin
      run_r     <= 1'b1;
      ucnt_r    <= 4'h0;
      unit_done <= 1'b0;
    end else if (run_r && ucnt_r >= unit_len) begin
      run_r     <= 1'b0;
      unit_done <= 1'b1;
    end else begin
      unit_done <= 1'b0;
      ucnt_r    <= ucnt_r + 4'h1;
    end
  end
endmodule : dca_bus_model

// ==== testbench/dma_channel_arbitration_test.sv ====
`timescale 1ns/1ps
`include "dca_map.svh"
module dma_channel_arbitration_test
  import dca_pkg::*;
;
  // table row: control word, requests, first owner expected
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0]  req;
    logic [7:0]  exp;
  } dca_row_type;
  logic            mclk, arst_n, unit_done, bus_req, bus_grant, ext_req, refresh_req;
  logic            nmi, standby, unit_start, unit_busy, dead_cycle, hit;
  dca_axi_req_type axi_req;
  dca_axi_rsp_type axi_rsp;
  logic [7:0]      xfer_req, act_ch, act;
  logic [3:0]      grant_wait, unit_len;
  logic [31:0]     rd;
  logic [1:0]      rs;
  int              n_mismatch, checks;
  dca_row_type     rows [8] = '{'{16'h00FF, 8'hFF, 8'h01}, '{16'h00FF, 8'hFE, 8'h02},
                                '{16'h00FF, 8'hF0, 8'h10}, '{16'h00FF, 8'h80, 8'h80},
                                '{16'h00FF, 8'h14, 8'h04}, '{16'h00FE, 8'h03, 8'h02},
                                '{16'h1101, 8'h01, 8'h01}, '{16'h1001, 8'h01, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////////
  dca_arbiter u_dut (.mclk(mclk), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .xfer_req(xfer_req), .unit_done(unit_done), .bus_req(bus_req), .bus_grant(bus_grant),
    .external_bus_request(ext_req), .refresh_req(refresh_req), .nmi(nmi), .standby(standby),
    .act_ch(act_ch), .unit_start(unit_start), .unit_busy(unit_busy), .dead_cycle(dead_cycle));
  dca_bus_model u_bus (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .unit_start(unit_start),
    .grant_wait(grant_wait), .unit_len(unit_len), .bus_grant(bus_grant), .unit_done(unit_done));
  // free-running clock, 8 ns period
  always #4 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one register access; entered and left just after a rising edge
  task automatic bus_op(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, tr, got;
    got = 1'b0;
    axi_req.awaddr  <= a;
    axi_req.araddr  <= a;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.awvalid <= wr;
    axi_req.wvalid  <= wr;
    axi_req.bready  <= wr;
    axi_req.arvalid <= !wr;
    axi_req.rready  <= !wr;
    while (!got) begin
      @(negedge mclk);
      ta  = axi_req.awvalid & axi_rsp.awready;
      tw  = axi_req.wvalid & axi_rsp.wready;
      tr  = axi_req.arvalid & axi_rsp.arready;
      got = (wr ? axi_rsp.bvalid : axi_rsp.rvalid) === 1'b1;
      q   = axi_rsp.rdata;
      r   = wr ? axi_rsp.bresp : axi_rsp.rresp;
      @(posedge mclk);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
      if (tr) axi_req.arvalid <= 1'b0;
    end
    axi_req.bready <= 1'b0;
    axi_req.rready <= 1'b0;
    @(posedge mclk);
  endtask : bus_op
  // wait n cycles at most for start (0), done (1) or dead cycle (2)
  task automatic wait_sig(input int sel, input int n, output logic h);
    h = 1'b0;
    act = 8'h00;
    repeat (n) begin
      @(negedge mclk);
      if ((sel == 0 ? unit_start : sel == 1 ? unit_done : dead_cycle) === 1'b1) begin
        h = 1'b1;
        act = act_ch;
      end
      @(posedge mclk);
      if (h) break;
    end
  endtask : wait_sig
  task automatic setup(input logic [15:0] c, input logic [7:0] m, input logic [7:0] q);
    bus_op(1'b1, `DCA_OFS_CTRL, {16'h0000, c}, rd, rs);
    bus_op(1'b1, `DCA_OFS_MODE, {24'h00_0000, m}, rd, rs);
    xfer_req <= q;
  endtask : setup
  // drop requests and disable everything, then let the bus settle
  task automatic clear;
    xfer_req <= 8'h00;
    setup(16'h0000, 8'h00, 8'h00);
    repeat (24) @(posedge mclk);
  endtask : clear
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    axi_req = '0;
    xfer_req = 8'h00;
    ext_req = 1'b0;
    refresh_req = 1'b0;
    nmi = 1'b0;
    standby = 1'b0;
    grant_wait = 4'h0;
    unit_len = 4'h3;
    repeat (5) @(posedge mclk);
    check("bus_req in reset", bus_req, 32'h0);
    arst_n <= 1'b1;
    @(posedge mclk);
    bus_op(1'b0, `DCA_OFS_CTRL, 32'h0, rd, rs);
    check("ctrl after reset", rd, 32'h0);
    bus_op(1'b0, 32'h0000_0010, 32'h0, rd, rs);
    check("unmapped read resp", {rd[29:0], rs}, 32'h2);
    bus_op(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd, rs);
    check("unmapped write resp", rs, 32'h2);
    $display("test reset done");
    // priority table, prompt and slow grants
    foreach (rows[i]) begin
      grant_wait <= i[0] ? 4'h5 : 4'h0;
      setup(rows[i].ctrl, 8'h00, rows[i].req);
      wait_sig(0, 40, hit);
      check("first owner", act, rows[i].exp);
      clear();
    end
    $display("test priority table done");
    // other group starts at once, same group waits for release
    setup(16'h00FF, 8'h00, 8'h11);
    wait_sig(0, 30, hit);
    wait_sig(1, 30, hit);
    @(negedge mclk);
    check("other group next", {bus_req, unit_start, act_ch}, 32'h310);
    @(posedge mclk);
    clear();
    setup(16'h00FF, 8'h00, 8'h03);
    wait_sig(0, 30, hit);
    xfer_req <= 8'h02;
    wait_sig(1, 30, hit);
    @(negedge mclk);
    check("release after unit", bus_req, 32'h0);
    @(posedge mclk);
    wait_sig(0, 30, hit);
    check("pending same group", act, 32'h02);
    clear();
    $display("test groups done");
    // burst keeps the bus, yields to another master, then re-requests
    for (int k = 0; k < 2; k++) begin
      setup(16'h00FF, 8'h01, 8'h01);
      wait_sig(0, 30, hit);
      wait_sig(1, 30, hit);
      @(negedge mclk);
      check("burst continues", {unit_busy, unit_start, act_ch}, 32'h301);
      @(posedge mclk);
      ext_req <= (k == 0);
      refresh_req <= (k == 1);
      wait_sig(1, 30, hit);
      @(negedge mclk);
      check("yield to master", bus_req, 32'h0);
      @(posedge mclk);
      ext_req <= 1'b0;
      refresh_req <= 1'b0;
      wait_sig(0, 30, hit);
      check("re-request", act, 32'h01);
      clear();
    end
    setup(16'h00FF, 8'h10, 8'h10);
    wait_sig(0, 30, hit);
    xfer_req <= 8'h11;
    wait_sig(0, 40, hit);
    check("group 0 preempts", act, 32'h01);
    clear();
    $display("test burst done");
    // suspension by nmi (k 0) and abort by channel enable (k 1)
    unit_len <= 4'hF;
    for (int k = 0; k < 2; k++) begin
      setup(k ? 16'h00FF : 16'h1101, 8'h00, 8'h01);
      wait_sig(0, 30, hit);
      if (k) bus_op(1'b1, `DCA_OFS_CTRL, 32'h0000_00FE, rd, rs);
      nmi <= !k;
      @(posedge mclk);
      nmi <= 1'b0;
      bus_op(1'b0, `DCA_OFS_CTRL, 32'h0, rd, rs);
      check("enables after halt", rd, k ? 32'h0000_00FE : 32'h0000_1001);
      bus_op(1'b0, `DCA_OFS_STAT, 32'h0, rd, rs);
      check("status while halting", rd, 32'h0003_0100);
      wait_sig(2, 40, hit);
      check("dead cycle", hit, 32'h1);
      wait_sig(0, 20, hit);
      check("halted", hit, 32'h0);
      bus_op(1'b1, `DCA_OFS_CTRL, k ? 32'h0000_00FF : 32'h0000_1101, rd, rs);
      wait_sig(0, 30, hit);
      check("restart", act, 32'h01);
      clear();
    end
    // nmi has no effect in short address mode
    setup(16'h0101, 8'h00, 8'h01);
    wait_sig(0, 30, hit);
    nmi <= 1'b1;
    @(posedge mclk);
    nmi <= 1'b0;
    bus_op(1'b0, `DCA_OFS_CTRL, 32'h0, rd, rs);
    check("short mode enables", rd, 32'h0000_0101);
    wait_sig(1, 30, hit);
    wait_sig(0, 30, hit);
    check("short mode goes on", act, 32'h01);
    $display("test halt done");
    // standby initialises a running channel
    standby <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    check("standby owner", {bus_req, act_ch}, 32'h0);
    @(posedge mclk);
    standby <= 1'b0;
    xfer_req <= 8'h00;
    bus_op(1'b0, `DCA_OFS_CTRL, 32'h0, rd, rs);
    check("standby ctrl", rd, 32'h0);
    $display("test standby done");
    report_and_stop();
  end
endmodule : dma_channel_arbitration_test
